//--- hdl/tw_port_map.vh
// Register offsets, field positions, reset values and constants of tw_port.
`ifndef TW_PORT_MAP_VH
`define TW_PORT_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define TW_ADDR_CTRL 8'hE8
`define TW_ADDR_OWN 8'h9B
`define TW_ADDR_DATA 8'h9A
`define TW_ADDR_SPI 8'hF8
`define TW_ADDR_IEN 8'hA9
`define TW_ADDR_IE 8'hA8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TW_CTRL_DOUT 7
`define TW_CTRL_DEN 6
`define TW_CTRL_COUT 5
`define TW_CTRL_DIN 4
`define TW_CTRL_MSEL 3
`define TW_CTRL_IRST 2
`define TW_CTRL_TX 1
`define TW_CTRL_FLAG 0
`define TW_SPI_PSEL 5
`define TW_IEN_PORT 0
`define TW_IE_GLOBAL 7

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define TW_RST_CTRL 8'h00
`define TW_RST_OWN 8'h55
`define TW_RST_DATA 8'h00
`define TW_RST_SPI 8'h00
`define TW_RST_IEN 8'h00
`define TW_RST_IE 8'h00
`define TW_INT_VECTOR 16'h003B
`define TW_BITS_PER_BYTE 4'h8

`endif

//--- hdl/tw_port.v
// Two-wire port: software master pins and hardware slave with SFR access.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tw_port_map.vh"

// What this block does
// RULE_01: Master select set gives software master; cleared gives hardware slave.
// RULE_02: With data drive enable set, data pin follows the data-out bit.
// RULE_03: In master mode the clock pin is always driven from clock-out bit.
// RULE_04: Software releases data and toggles the clock bit to receive.
// RULE_05: Data pin level is captured into data-in on each clock rise; the code captures only while drive enable is clear.
// RULE_06: Software sequences START, address, acks, data and STOP as master.
// RULE_07: After reset the port is in hardware slave mode.
// RULE_08: Port works only while the peripheral select bit is clear.
// RULE_09: Slave matches own address and uses the data register both ways.
// RULE_10: Slave sets the byte flag after START, matching address and direction.
// RULE_11: Interrupt raised only with port enable and global enable set.
// RULE_12: Any data register read or write clears the byte flag.
// RULE_13: A second data access per interrupt halts until interface reset.
// RULE_14: With interrupts on, vector to the port address after each byte.
// RULE_15: First interrupt shows received address and direction in data reg.
// RULE_16: Direction bit mirrors master's read/write; set means slave sends.
// RULE_17: After valid address slave holds clock low until flag clears.
// RULE_18: Flag set per acknowledged byte; a not-acknowledged byte sets none.
// RULE_19: Flags continue for every acked byte until STOP or reset.
// RULE_20: STOP or not-acknowledge returns the slave to idle.
// RULE_21: Interface reset bit forces the slave to its idle state.
// RULE_22: Address and data interrupts are indistinguishable in hardware.
// RULE_23: Interface reset bit holds reset while set; software clears it.
// RULE_24: Data-in updates on clock edges only while drive enable is zero.
// RULE_25: Own address powers up with a default and stays writable.
module tw_port (
  input wire clk_sys,
  input wire nrst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output wire [7:0] regRdData,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  input wire sclIn,
  output wire sclOut,
  output wire sclOe,
  output wire irq,
  output wire [15:0] intVector
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_RBIT = 3'h4;
  localparam [2:0] ST_TBIT = 3'h5;
  localparam [2:0] ST_TACK = 3'h6;
  localparam [2:0] ST_HALT = 3'h7;

  function edgeOf;
    input prev;
    input cur;
    input rising;
    begin
      edgeOf = rising ? (!prev && cur) : (prev && !cur);
    end
  endfunction

  function isReg;
    input [7:0] addr;
    input [7:0] target;
    begin
      isReg = addr == target;
    end
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Stage one is read only by stage two; edges come from stages two and three.
  reg sdaS1_q, sdaS2_q, sdaS3_q;
  reg sclS1_q, sclS2_q, sclS3_q;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sdaS1_q <= 1'b1;
      sdaS2_q <= 1'b1;
      sdaS3_q <= 1'b1;
      sclS1_q <= 1'b1;
      sclS2_q <= 1'b1;
      sclS3_q <= 1'b1;
    end else begin
      sdaS1_q <= sdaIn;
      sdaS2_q <= sdaS1_q;
      sdaS3_q <= sdaS2_q;
      sclS1_q <= sclIn;
      sclS2_q <= sclS1_q;
      sclS3_q <= sclS2_q;
    end
  end

  wire sclRise = edgeOf(sclS3_q, sclS2_q, 1'b1);
  wire sclFall = edgeOf(sclS3_q, sclS2_q, 1'b0);
  wire startSeen = sclS2_q && sclS3_q && edgeOf(sdaS3_q, sdaS2_q, 1'b0);
  wire stopSeen = sclS2_q && sclS3_q && edgeOf(sdaS3_q, sdaS2_q, 1'b1);

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  reg [7:0] ctrl_q;
  reg [7:0] ownAddr_q;
  reg [7:0] data_q, data_d;
  reg [7:0] spi_q;
  reg [7:0] ien_q;
  reg [7:0] ie_q;
  reg [7:0] rdData_q, rdData_d;
  reg flag_q, flag_d;
  reg txDir_q, txDir_d;
  reg din_q;
  reg accessed_q, accessed_d;

  wire masterMode = ctrl_q[`TW_CTRL_MSEL];
  wire ifaceRst = ctrl_q[`TW_CTRL_IRST];
  wire portOn = !spi_q[`TW_SPI_PSEL];
  wire dataAcc = (regWr || regRd) && isReg(regAddr, `TW_ADDR_DATA);
  wire slaveRun = portOn && !masterMode && !ifaceRst;

  // Reset values below put the port in slave mode.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `TW_RST_CTRL; // [RULE_07]
      ownAddr_q <= `TW_RST_OWN; // [RULE_25]
      spi_q <= `TW_RST_SPI;
      ien_q <= `TW_RST_IEN;
      ie_q <= `TW_RST_IE;
    end else if (regWr) begin
      case (regAddr)
        `TW_ADDR_CTRL: ctrl_q[7:2] <= regWrData[7:2];
        `TW_ADDR_OWN: ownAddr_q <= regWrData; // [RULE_25]
        `TW_ADDR_SPI: spi_q <= regWrData;
        `TW_ADDR_IEN: ien_q <= regWrData;
        `TW_ADDR_IE: ie_q <= regWrData;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Data-in is a latch of the pin on clock rise with the driver off.
  // It also follows the pin in slave mode, so read it only as master.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      din_q <= 1'b0;
    end else if (sclRise && !ctrl_q[`TW_CTRL_DEN]) begin // [RULE_05] [RULE_24]
      din_q <= sdaS2_q;
    end
  end

  // Read data stand in the cycle after the strobe only.
  always @* begin
    rdData_d = 8'h00;
    if (regRd) begin
      case (regAddr)
        `TW_ADDR_CTRL: rdData_d = {ctrl_q[7:5], din_q, ctrl_q[3:2],
                                   txDir_q, flag_q}; // [RULE_22]
        `TW_ADDR_OWN: rdData_d = ownAddr_q;
        `TW_ADDR_DATA: rdData_d = data_q;
        `TW_ADDR_SPI: rdData_d = spi_q;
        `TW_ADDR_IEN: rdData_d = ien_q;
        `TW_ADDR_IE: rdData_d = ie_q;
        default: rdData_d = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Hardware slave
  // --------------------------------------------------------------------
  reg [2:0] state_q, state_d;
  reg [7:0] shift_q, shift_d;
  reg [3:0] bitCnt_q, bitCnt_d;
  reg drvLow_q, drvLow_d;
  reg flagSet;

  always @* begin
    state_d = state_q;
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    drvLow_d = drvLow_q;
    txDir_d = txDir_q;
    flagSet = 1'b0;
    data_d = data_q;
    if (regWr && isReg(regAddr, `TW_ADDR_DATA)) begin
      data_d = regWrData;
    end
    if (!slaveRun) begin
      // Held idle while reset bit is set or master mode owns the pins.
      state_d = ST_IDLE; // [RULE_21] [RULE_23] [RULE_08]
      drvLow_d = 1'b0;
      bitCnt_d = 4'h0;
    end else if (state_q == ST_HALT) begin
      // A halted slave ignores START and STOP; only nrst, the reset bit, master mode or port off frees it.
      drvLow_d = 1'b0; // [RULE_13]
    end else if (dataAcc && accessed_q) begin
      state_d = ST_HALT; // [RULE_13]
      drvLow_d = 1'b0;
    end else if (stopSeen) begin
      state_d = ST_IDLE; // [RULE_20] [RULE_19]
      drvLow_d = 1'b0;
    end else if (startSeen) begin
      state_d = ST_ADDR; // [RULE_10]
      bitCnt_d = 4'h0;
      drvLow_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          drvLow_d = 1'b0;
        end
        ST_ADDR, ST_RBIT: begin
          if (sclRise) begin
            shift_d = {shift_q[6:0], sdaS2_q};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == `TW_BITS_PER_BYTE) begin
            bitCnt_d = 4'h0;
            if (state_q == ST_RBIT ||
                shift_q[7:1] == ownAddr_q[6:0]) begin // [RULE_09]
              data_d = shift_q; // [RULE_15] [RULE_09]
              flagSet = 1'b1; // [RULE_10] [RULE_18]
              drvLow_d = 1'b1;
              state_d = ST_ACK;
              if (state_q == ST_ADDR) begin
                txDir_d = shift_q[0]; // [RULE_16]
              end
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            drvLow_d = 1'b0;
            state_d = ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Clock stays low here until software has serviced the byte.
          if (!flag_q) begin // [RULE_17]
            if (txDir_q) begin
              shift_d = {data_q[6:0], 1'b0};
              drvLow_d = !data_q[7]; // [RULE_16]
              bitCnt_d = 4'h1;
              state_d = ST_TBIT;
            end else begin
              bitCnt_d = 4'h0;
              state_d = ST_RBIT;
            end
          end
        end
        ST_TBIT: begin
          // Each bit changes after a fall, so it is stable before the rise.
          if (sclFall) begin
            if (bitCnt_q == `TW_BITS_PER_BYTE) begin
              drvLow_d = 1'b0;
              state_d = ST_TACK;
            end else begin
              drvLow_d = !shift_q[7];
              shift_d = {shift_q[6:0], 1'b0};
              bitCnt_d = bitCnt_q + 4'h1;
            end
          end
        end
        ST_TACK: begin
          // The master's acknowledge decides whether another byte follows.
          if (sclRise) begin
            if (sdaS2_q) begin
              state_d = ST_IDLE; // [RULE_18] [RULE_20]
            end else begin
              flagSet = 1'b1; // [RULE_18] [RULE_19]
              state_d = ST_ACK;
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // Set wins over the clear from a data access in the same cycle.
  always @* begin
    flag_d = flag_q;
    accessed_d = accessed_q;
    if (!slaveRun) begin
      flag_d = 1'b0; // [RULE_21]
      accessed_d = 1'b0;
    end else if (flagSet) begin
      flag_d = 1'b1;
      accessed_d = 1'b0;
    end else if (dataAcc) begin
      flag_d = 1'b0; // [RULE_12]
      accessed_d = 1'b1; // [RULE_13]
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bitCnt_q <= 4'h0;
      drvLow_q <= 1'b0;
      txDir_q <= 1'b0;
      flag_q <= 1'b0;
      accessed_q <= 1'b0;
      data_q <= `TW_RST_DATA;
      rdData_q <= 8'h00;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bitCnt_q <= bitCnt_d;
      drvLow_q <= drvLow_d;
      txDir_q <= txDir_d;
      flag_q <= flag_d;
      accessed_q <= accessed_d;
      data_q <= data_d;
      rdData_q <= rdData_d;
    end
  end

  // --------------------------------------------------------------------
  // Pin drivers and interrupt
  // --------------------------------------------------------------------
  // Master mode drives the clock push-pull, and data too while drive enable is set; the slave only pulls low.
  reg sdaOut_q, sdaOe_q, sclOut_q, sclOe_q, irq_q;
  reg [15:0] vec_q;
  wire slaveHold = slaveRun && state_q == ST_HOLD && flag_q;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sdaOut_q <= 1'b0;
      sdaOe_q <= 1'b0;
      sclOut_q <= 1'b0;
      sclOe_q <= 1'b0;
      irq_q <= 1'b0;
      vec_q <= `TW_INT_VECTOR;
    end else begin
      if (portOn && masterMode) begin // [RULE_01] [RULE_08]
        sdaOut_q <= ctrl_q[`TW_CTRL_DOUT]; // [RULE_02]
        sdaOe_q <= ctrl_q[`TW_CTRL_DEN]; // [RULE_02]
        sclOut_q <= ctrl_q[`TW_CTRL_COUT]; // [RULE_03]
        sclOe_q <= 1'b1; // [RULE_03]
      end else begin
        sdaOut_q <= 1'b0;
        sdaOe_q <= slaveRun && drvLow_q; // [RULE_01]
        sclOut_q <= 1'b0;
        sclOe_q <= slaveHold; // [RULE_17]
      end
      irq_q <= portOn && !masterMode && flag_q && ien_q[`TW_IEN_PORT] &&
               ie_q[`TW_IE_GLOBAL]; // [RULE_11] [RULE_14]
      vec_q <= `TW_INT_VECTOR; // [RULE_14]
    end
  end

  assign regRdData = rdData_q;
  assign sdaOut = sdaOut_q;
  assign sdaOe = sdaOe_q;
  assign sclOut = sclOut_q;
  assign sclOe = sclOe_q;
  assign irq = irq_q;
  assign intVector = vec_q;

endmodule
`default_nettype wire

//--- bench/tw_port_monitor.sv
// Concurrent checks on the ports of the two-wire port.
`timescale 1ns/1ps
`default_nettype none
module tw_port_monitor (
  input wire clk_sys,
  input wire nrst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdData,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe,
  input wire sclIn,
  input wire sclOut,
  input wire sclOe,
  input wire irq,
  input wire [15:0] intVector
);
  // ------------------------------------------------------------
  // Shadow copies of the control bits and own address
  // ------------------------------------------------------------
  logic msel_q, irst_q, off_q, ien_q, ie_q;
  logic [7:0] own_q;
  wire ctlWr = regWr && regAddr == 8'hE8;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {msel_q, irst_q, off_q, ien_q, ie_q} <= 5'h00;
      own_q <= 8'h55;
    end else begin
      if (ctlWr) msel_q <= regWrData[3];
      if (ctlWr) irst_q <= regWrData[2];
      if (regWr && regAddr == 8'hF8) off_q <= regWrData[5];
      if (regWr && regAddr == 8'hA9) ien_q <= regWrData[0];
      if (regWr && regAddr == 8'hA8) ie_q <= regWrData[7];
      if (regWr && regAddr == 8'h9B) own_q <= regWrData;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  vector_fixed_a: assert property (intVector == 16'h003B)
    else $error("interrupt vector wrong");
  read_idle_a: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data outside read cycle");
  own_read_a: assert property (regRd && regAddr == 8'h9B |=>
    regRdData == $past(own_q)) else $error("own address readback");
  irq_gate_a: assert property (irq |-> $past(ien_q) && $past(ie_q) &&
    !$past(off_q) && !$past(msel_q)) else $error("irq not gated");
  scl_follow_a: assert property (ctlWr && regWrData[3] && !off_q |->
    ##2 sclOe && sclOut == $past(regWrData[5], 2))
    else $error("clock pin not following");
  sda_follow_a: assert property (ctlWr && regWrData[3] && !off_q |->
    ##2 sdaOe == $past(regWrData[6], 2) &&
    (!sdaOe || sdaOut == $past(regWrData[7], 2)))
    else $error("data pin not following");
  port_off_a: assert property (off_q && $past(off_q) |->
    !sclOe && !sdaOe && !irq) else $error("port active while off");
  slave_drain_a: assert property (!msel_q && !$past(msel_q) |->
    !(sdaOe && sdaOut) && !(sclOe && sclOut))
    else $error("slave drives a pin high");
  irst_idle_a: assert property (irst_q && $past(irst_q) && !msel_q |->
    !sclOe && !sdaOe && !irq) else $error("not idle in reset");
  access_clear_a: assert property ((regRd || regWr) && regAddr == 8'h9A |->
    ##2 !irq) else $error("irq survives data access");
endmodule
`default_nettype wire

//--- bench/tw_far_master.sv
// Behavioural far-side bus master with open-drain pins.
`timescale 1ns/1ps
`default_nettype none
module tw_far_master (
  input wire logic sdaLine,
  input wire logic sclLine,
  output logic sdaLow,
  output logic sclLow,
  output logic [7:0] hung
);
  initial begin
    sdaLow = 1'b0;
    sclLow = 1'b0;
    hung = 8'h00;
  end
  // The slave may stretch the clock, so the rise is awaited with a bound.
  task automatic relScl();
    int n = 0;
    sclLow = 1'b0;
    while (!sclLine && n < 4000) #5 n++;
    if (n == 4000) hung++;
  endtask
  task automatic clkBit(output logic s);
    #40 relScl();
    s = sdaLine;
    #80 sclLow = 1'b1;
    #40;
  endtask
  task automatic start();
    #1 sdaLow = 1'b1;
    #80 sclLow = 1'b1;
    #40;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    #1;
    for (int i = 7; i >= 0; i--) begin
      sdaLow = !b[i];
      clkBit(s);
    end
    sdaLow = 1'b0;
    clkBit(s);
    ack = !s;
  endtask
  // Reads one byte from the slave, then acknowledges it or not.
  task automatic recvByte(input logic nack, output logic [7:0] b);
    logic s;
    #1;
    for (int i = 7; i >= 0; i--) begin
      sdaLow = 1'b0;
      clkBit(s);
      b[i] = s;
    end
    sdaLow = !nack;
    clkBit(s);
    sdaLow = 1'b0;
  endtask
  task automatic stop();
    #1 sdaLow = 1'b1;
    #40 relScl();
    #40 sdaLow = 1'b0;
    #80;
  endtask
endmodule
`default_nettype wire

//--- bench/tw_port_bench.sv
// Self-checking bench of the two-wire port.
`timescale 1ns/1ps
`default_nettype none
module tw_port_bench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  wire [7:0] regRdData;
  wire [15:0] intVector;
  wire sdaOut, sdaOe, sclOut, sclOe, irq, sdaLow, sclLow;
  wire [7:0] hung;
  // Both lines carry pull-ups; any party may pull them low.
  wire sdaLine = (sdaOe ? sdaOut : 1'b1) & !sdaLow;
  wire sclLine = (sclOe ? sclOut : 1'b1) & !sclLow;
  wire [7:0] pins = {4'h0, sdaOe, sdaOut, sclOe, sclOut};
  int n_mismatch = 0;
  int num_checks = 0;
  logic [7:0] rd;
  logic ack;
  logic [23:0] rows [8] = '{24'h9B_2A2A, 24'h10_FF00, 24'hE8_0300,
    24'hF8_2020, 24'hF8_0000, 24'hA9_0101, 24'hA8_8080, 24'h9B_5555};
  always #2.5 clk_sys = ~clk_sys;
  tw_port i_tw_port (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .irq(irq),
    .intVector(intVector));
  tw_far_master i_tw_far_master (.sdaLine(sdaLine), .sclLine(sclLine),
    .sdaLow(sdaLow), .sclLow(sclLow), .hung(hung));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {regAddr, regWrData, regWr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    {regAddr, regRd} <= {a, 1'b1};
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400_000 n_mismatch++;
    wrap_up();
  end
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    idle(3);
    nrst <= 1'b1;
    rdReg(8'hE8, rd);
    chk8(rd, 8'h00);
    chk8(intVector[15:8], 8'h00);
    chk8(intVector[7:0], 8'h3B);
    foreach (rows[i]) begin
      wrReg(rows[i][23:16], rows[i][15:8]);
      rdReg(rows[i][23:16], rd);
      chk8(rd, rows[i][7:0]);
    end
    wrReg(8'hE8, 8'hE8);
    idle(2);
    chk8(pins, 8'h0F);
    wrReg(8'hE8, 8'h48);
    idle(2);
    chk8(pins, 8'h0A);
    for (int v = 0; v < 2; v++) begin
      force_low(v);
    end
    wrReg(8'hE8, 8'hC8);
    wrReg(8'hE8, 8'hE8);
    idle(8);
    rdReg(8'hE8, rd);
    chk8(rd, 8'hE8);
    wrReg(8'hF8, 8'h20);
    idle(3);
    chk8(pins, 8'h00);
    wrReg(8'hF8, 8'h00);
    wrReg(8'hE8, 8'h00);
    i_tw_far_master.start();
    i_tw_far_master.sendByte(8'hAA, ack);
    idle(4);
    chk8({5'h00, ack, irq, sclOe}, 8'h07);
    rdReg(8'hE8, rd);
    chk8(rd, 8'h01);
    rdReg(8'h9A, rd);
    chk8(rd, 8'hAA);
    idle(4);
    chk8({6'h00, irq, sclOe}, 8'h00);
    i_tw_far_master.sendByte(8'h3C, ack);
    idle(4);
    rdReg(8'hE8, rd);
    chk8(rd, 8'h01);
    chk8({7'h00, ack}, 8'h01);
    rdReg(8'h9A, rd);
    chk8(rd, 8'h3C);
    rdReg(8'h9A, rd);
    i_tw_far_master.sendByte(8'h77, ack);
    chk8({7'h00, ack}, 8'h00);
    i_tw_far_master.stop();
    wrReg(8'hE8, 8'h04);
    idle(3);
    wrReg(8'hE8, 8'h00);
    i_tw_far_master.start();
    i_tw_far_master.sendByte(8'hAB, ack);
    idle(4);
    rdReg(8'hE8, rd);
    chk8(rd, 8'h03);
    wrReg(8'h9A, 8'hC5);
    i_tw_far_master.recvByte(1'b0, rd);
    chk8(rd, 8'hC5);
    idle(4);
    rdReg(8'hE8, rd);
    chk8(rd, 8'h03);
    wrReg(8'h9A, 8'h3A);
    i_tw_far_master.recvByte(1'b1, rd);
    chk8(rd, 8'h3A);
    idle(4);
    rdReg(8'hE8, rd);
    // Data-in caught the released line at the not-acknowledge rise.
    chk8(rd, 8'h12);
    i_tw_far_master.stop();
    i_tw_far_master.start();
    i_tw_far_master.sendByte(8'h54, ack);
    chk8({7'h00, ack}, 8'h00);
    i_tw_far_master.stop();
    wrReg(8'h9B, 8'h2A);
    wrReg(8'hE8, 8'h08);
    nrst <= 1'b0;
    idle(3);
    nrst <= 1'b1;
    rdReg(8'hE8, rd);
    chk8(rd, 8'h00);
    rdReg(8'h9B, rd);
    chk8(rd, 8'h55);
    chk8(hung, 8'h00);
    wrap_up();
  end
  // Software-master receive: release data, raise the clock bit, read back.
  task automatic force_low(input int v);
    i_tw_far_master.sdaLow <= v[0];
    wrReg(8'hE8, 8'h08);
    wrReg(8'hE8, 8'h28);
    idle(8);
    rdReg(8'hE8, rd);
    chk8(rd, v[0] ? 8'h28 : 8'h38);
    i_tw_far_master.sdaLow = 1'b0;
  endtask
endmodule
bind tw_port tw_port_monitor i_tw_port_monitor (.clk_sys(clk_sys),
  .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
  .irq(irq), .intVector(intVector));
`default_nettype wire
